// file: core/sfp_pkg.sv
// Constants, register map and pin carrier for the sector flash program controller.
// Assumes a 40 MHz hclk and one byte-wide asynchronous flash on the pin group.
package sfp_pkg;

  // Clock
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_NS  = 25;

  // Pin timing, each time in its own unit, then in cycles
  localparam int unsigned SETUP_NS      = 25;
  localparam int unsigned STROBE_NS     = 70;
  localparam int unsigned HOLD_NS       = 25;
  localparam int unsigned READ_NS       = 120;
  localparam int unsigned RECOVER_NS    = 50;
  localparam int unsigned LOAD_GAP_US   = 150;
  localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_CYC      = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RECOVER_CYC   = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LOAD_GAP_CYC  = LOAD_GAP_US * CLK_MHZ;
  localparam int unsigned TMR_W         = 8;
  localparam int unsigned GAP_W         = 16;

  // Flash geometry
  localparam int unsigned FA_W          = 18;
  localparam int unsigned FD_W          = 8;
  localparam int unsigned SECTOR_BYTES  = 256;
  localparam int unsigned SECTOR_LSB    = 8;
  localparam logic [17:0] LOW_LOCK_ADDR = 18'h00002;
  localparam logic [17:0] UP_LOCK_ADDR  = 18'h3fff2;
  localparam logic [7:0]  LOCK_OPEN     = 8'hfe;
  localparam logic [7:0]  LOCK_SET      = 8'hff;
  localparam int unsigned POLL_BIT      = 7;
  localparam int unsigned TOGGLE_BIT    = 6;

  // Register offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Command codes written to REG_CMD[1:0]
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_LOAD = 2'h2;
  localparam logic [1:0] CMD_POLL = 2'h3;

  // Status bit positions
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_WINDOW = 1;
  localparam int unsigned ST_DONE   = 2;

  // Pin outputs toward the flash
  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic            ce_n;
    logic            oe_n;
    logic            we_n;
    logic [FD_W-1:0] dq_out;
    logic            dq_oe;
  } sfp_pins_t;

  localparam sfp_pins_t PINS_IDLE = '{addr: 18'h00000, ce_n: 1'b1, oe_n: 1'b1,
                                      we_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_RD    = 7'b0000010,
    S_SETUP = 7'b0000100,
    S_LOW   = 7'b0001000,
    S_HOLD  = 7'b0010000,
    S_POLL  = 7'b0100000,
    S_GAP   = 7'b1000000
  } sfp_state_t;

endpackage : sfp_pkg

// file: core/sfp_ctrl.sv
// Host-side controller for a byte-wide sector-programmed flash, with AHB-Lite registers.
// Assumes one flash on the pin group; dq_in is the resolved data bus, synchronous to hclk.
// Behaviour
// - Byte load pulses write strobe low under low chip select, output enable high.
// - Software must load every byte of a sector it changes.
// - Next byte within 150 us of the previous rise; a window bit shows it.
// - Sector address bits stay stable across each falling strobe edge.
// - Protection enable is three timed loads issued by software.
// - With protection on, each program cycle starts with the three loads.
// - Chip erase is a six-byte load sequence from software.
// - Boot lockout is seven timed loads issued by software.
`timescale 1ns/1ps
`default_nettype none
module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter int unsigned LOAD_GAP_CYCLES = LOAD_GAP_CYC
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // Flash pins
  output sfp_pins_t             pins,
  input  wire logic [FD_W-1:0]  dq_in
);

  sfp_state_t        st_r,     st_nxt;
  sfp_pins_t         pins_r,   pins_nxt;
  logic [TMR_W-1:0]  tmr_r,    tmr_nxt;
  logic [GAP_W-1:0]  gap_r,    gap_nxt;
  logic [FA_W-1:0]   addr_r,   addr_nxt;
  logic [FD_W-1:0]   wdata_r,  wdata_nxt;
  logic [FD_W-1:0]   rdata_r,  rdata_nxt;
  logic              done_r,   done_nxt;
  logic              first_r,  first_nxt;
  logic              prev_r,   prev_nxt;
  logic              wpend_r,  wpend_nxt;
  logic [7:0]        wa_r,     wa_nxt;
  logic [31:0]       hrdata_r, hrdata_nxt;
  logic              busy;
  logic              take;

  assign busy      = (st_r != S_IDLE);
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign pins      = pins_r;

  always_comb begin
    st_nxt     = st_r;
    pins_nxt   = pins_r;
    tmr_nxt    = tmr_r;
    gap_nxt    = gap_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    rdata_nxt  = rdata_r;
    done_nxt   = done_r;
    first_nxt  = first_r;
    prev_nxt   = prev_r;
    hrdata_nxt = hrdata_r;
    wpend_nxt  = take && hwrite;
    wa_nxt     = take ? haddr[7:0] : wa_r;

    // Load window counter, reloaded on each strobe rise
    if (gap_r != '0) begin
      gap_nxt = gap_r - 1'b1;
    end

    // Read data is registered during the address phase
    if (take && !hwrite) begin
      case (haddr[7:0])
        REG_ADDR:   hrdata_nxt = {14'h0000, addr_r};
        REG_WDATA:  hrdata_nxt = {24'h000000, wdata_r};
        REG_RDATA:  hrdata_nxt = {24'h000000, rdata_r};
        REG_STATUS: hrdata_nxt = {29'h00000000, done_r, (gap_r != '0), busy};
        default:    hrdata_nxt = 32'h00000000;
      endcase
    end

    // Register writes in the data phase; a command while busy is dropped
    if (wpend_r) begin
      case (wa_r)
        REG_ADDR:   addr_nxt  = hwdata[FA_W-1:0];
        REG_WDATA:  wdata_nxt = hwdata[FD_W-1:0];
        REG_STATUS: if (hwdata[ST_DONE]) begin
          done_nxt = 1'b0;
        end
        REG_CMD: if (!busy) begin
          pins_nxt.addr = addr_r;
          tmr_nxt       = TMR_W'(READ_CYC - 1);
          case (hwdata[1:0])
            CMD_READ: begin
              pins_nxt.ce_n = 1'b0;
              pins_nxt.oe_n = 1'b0;
              st_nxt        = S_RD;
            end
            // Protect, erase, lockout and ID codes are software load sequences
            CMD_LOAD: begin
              pins_nxt.ce_n   = 1'b0;
              pins_nxt.oe_n   = 1'b1;
              pins_nxt.dq_out = wdata_r;
              pins_nxt.dq_oe  = 1'b1;
              tmr_nxt         = TMR_W'(SETUP_CYC - 1);
              st_nxt          = S_SETUP;
            end
            CMD_POLL: begin
              pins_nxt.ce_n = 1'b0;
              pins_nxt.oe_n = 1'b0;
              first_nxt     = 1'b1;
              st_nxt        = S_POLL;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    case (st_r)
      S_IDLE: ;
      S_RD: begin
        if (tmr_r == '0) begin
          rdata_nxt     = dq_in;
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          st_nxt        = S_IDLE;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      S_SETUP: begin
        // Address and sector bits already stable before the fall
        if (tmr_r == '0) begin
          pins_nxt.we_n = 1'b0;
          tmr_nxt       = TMR_W'(STROBE_CYC - 1);
          st_nxt        = S_LOW;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      S_LOW: begin
        if (tmr_r == '0) begin
          pins_nxt.we_n = 1'b1;
          gap_nxt       = GAP_W'(LOAD_GAP_CYCLES);
          tmr_nxt       = TMR_W'(HOLD_CYC - 1);
          st_nxt        = S_HOLD;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      S_HOLD: begin
        if (tmr_r == '0) begin
          pins_nxt.ce_n  = 1'b1;
          pins_nxt.dq_oe = 1'b0;
          st_nxt         = S_IDLE;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      S_POLL: begin
        if (tmr_r == '0) begin
          rdata_nxt     = dq_in;
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          prev_nxt      = dq_in[TOGGLE_BIT];
          first_nxt     = 1'b0;
          tmr_nxt       = TMR_W'(RECOVER_CYC - 1);
          if (!first_r && (dq_in[TOGGLE_BIT] == prev_r)) begin
            done_nxt = 1'b1;
            st_nxt   = S_IDLE;
          end else begin
            st_nxt = S_GAP;
          end
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      S_GAP: begin
        // Each poll is a fresh access so the toggle bit advances
        if (tmr_r == '0) begin
          pins_nxt.ce_n = 1'b0;
          pins_nxt.oe_n = 1'b0;
          tmr_nxt       = TMR_W'(READ_CYC - 1);
          st_nxt        = S_POLL;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      default: begin
        st_nxt   = S_IDLE;
        pins_nxt = PINS_IDLE;
      end
    endcase

    // Never drive data while the flash may drive it
    if (!pins_nxt.oe_n) begin
      pins_nxt.dq_oe = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= S_IDLE;
      pins_r   <= PINS_IDLE;
      tmr_r    <= '0;
      gap_r    <= '0;
      addr_r   <= '0;
      wdata_r  <= '0;
      rdata_r  <= '0;
      done_r   <= 1'b0;
      first_r  <= 1'b0;
      prev_r   <= 1'b0;
      wpend_r  <= 1'b0;
      wa_r     <= '0;
      hrdata_r <= '0;
    end else begin
      st_r     <= st_nxt;
      pins_r   <= pins_nxt;
      tmr_r    <= tmr_nxt;
      gap_r    <= gap_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      rdata_r  <= rdata_nxt;
      done_r   <= done_nxt;
      first_r  <= first_nxt;
      prev_r   <= prev_nxt;
      wpend_r  <= wpend_nxt;
      wa_r     <= wa_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

endmodule : sfp_ctrl
`default_nettype wire

// file: core/unused_placeholder_none.sv
// Intentionally empty: all logic is in sfp_ctrl.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: sim/sfp_ctrl_assertions.sv
// Pin-level timing checks for the sector flash program controller.
// Bound to sfp_ctrl; sees only its clock, reset and flash pins.
`timescale 1ns/1ps
`default_nettype none
module sfp_ctrl_assertions
  import sfp_pkg::*;
(
  // Clock and reset
  input wire logic      hclk,
  input wire logic      hresetn,
  // Flash pins
  input wire sfp_pins_t pins
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_NO_CONTENTION: assert property (!pins.oe_n |-> !pins.dq_oe)
    else $error("data driven while output enable low");
  AST_READ_PINS: assert property (!pins.oe_n |-> pins.we_n && !pins.ce_n)
    else $error("read without chip select or with strobe low");
  AST_READ_LEN: assert property ($fell(pins.oe_n) |-> !pins.oe_n [*5] ##1 pins.oe_n)
    else $error("read strobe not five cycles");
  AST_LOAD_PINS: assert property (!pins.we_n |-> pins.oe_n && !pins.ce_n)
    else $error("load with output enable low");
  AST_WE_WIDTH: assert property ($fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n)
    else $error("write strobe not three cycles");
  AST_WE_SETUP: assert property ($fell(pins.we_n) |-> !$past(pins.ce_n) && $past(pins.dq_oe))
    else $error("strobe fell without setup");
  AST_ADDR_STABLE: assert property (!pins.we_n |-> $stable(pins.addr))
    else $error("address moved under the strobe");
  AST_DATA_HOLD: assert property ($rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out))
    else $error("data not held at strobe rise");
endmodule : sfp_ctrl_assertions

bind sfp_ctrl sfp_ctrl_assertions sfp_ctrl_assertions_i (.hclk(hclk), .hresetn(hresetn),
                                                         .pins(pins));
`default_nettype wire

// file: sim/sfp_flash_model.sv
// Behavioural byte-wide sector flash driven by the controller pins.
// Assumes the bench resolves the data bus; write protection is not modelled.
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_model
  import sfp_pkg::*;
#(
  parameter int GAP_NS = 1250,
  parameter int WC_NS  = 3000,
  parameter int PON_NS = 100
) (
  // Pins from the controller
  input  wire sfp_pins_t  pins,
  // Data bus drive
  output logic [FD_W-1:0] dq_drv,
  output logic            dq_en
);
  bit [7:0]    mem [bit [17:0]];
  logic [17:0] la;
  logic [7:0]  last_d = 8'h00;
  logic        busy   = 1'b0;
  logic        tog    = 1'b0;
  logic        armed  = 1'b0;
  realtime     t_fall = 0;
  realtime     t_rise = 0;
  // Protection is off as delivered and never enabled here
  // Erase and boot lockout codes would arrive as plain loads; none are sent
  always @(negedge pins.we_n) if (!pins.ce_n && pins.oe_n) begin
    la = pins.addr;
    t_fall = $realtime;
  end
  // Short pulses and loads before the power-on delay are dropped
  always @(posedge pins.we_n) if (!pins.ce_n && pins.oe_n && !busy
                                   && $realtime - t_fall >= 15 && $realtime >= PON_NS) begin
    mem[la] = pins.dq_out;
    last_d = pins.dq_out;
    t_rise = $realtime;
    armed = 1'b1;
  end
  always #100 if (armed && pins.we_n && $realtime - t_rise > GAP_NS) begin
    armed = 1'b0;
    busy = 1'b1;
    #WC_NS;
    busy = 1'b0;
  end
  always @(negedge pins.oe_n) if (busy) tog = ~tog;
  assign dq_en = !pins.ce_n && !pins.oe_n && pins.we_n;
  always @(pins or busy or tog) begin
    if (busy) dq_drv = {~last_d[7], tog, last_d[5:0]};
    else if (mem.exists(pins.addr)) dq_drv = mem[pins.addr];
    else dq_drv = 8'hff;
  end
endmodule : sfp_flash_model
`default_nettype wire

// file: sim/sector_flash_program_control_bench.sv
// Self-checking bench: AHB-Lite master, flash model, queued read checks.
// Assumes pull-ups on the flash data bus.
`timescale 1ns/1ps
`default_nettype none
module sector_flash_program_control_bench
  import sfp_pkg::*;
;
  localparam int GAP = 50;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_dp = 0, hreadyout, hresp, dq_en;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [7:0]  dq_in, dq_drv, d [3];
  logic [63:0] note, exp_q [$];
  sfp_pins_t   pins;
  int          fails = 0, comparisons = 0, cyc = 0;
  initial forever #12.5 hclk = ~hclk;
  sfp_ctrl #(.LOAD_GAP_CYCLES(GAP)) sfp_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pins(pins), .dq_in(dq_in));
  sfp_flash_model #(.GAP_NS(GAP * 25)) sfp_flash_model_i (.pins(pins), .dq_drv(dq_drv),
    .dq_en(dq_en));
  assign dq_in = pins.dq_oe ? pins.dq_out : dq_en ? dq_drv : 8'hff;
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] e, m, g);
    comparisons++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("wrong value t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask : cmp
  // Reads note their expectation; the watcher compares in the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v, m,
                     output logic [31:0] q);
    if (!w) exp_q.push_back({m, v});
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= w ? v : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    ahb(1'b1, a, v, 32'h0, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    logic [31:0] q;
    ahb(1'b0, a, e, m, q);
  endtask : rd
  task automatic cmd(input logic [1:0] c, input logic [17:0] fa, input logic [7:0] v);
    logic [31:0] q;
    int          n;
    wr(REG_ADDR, {14'h0, fa});
    wr(REG_WDATA, {24'h0, v});
    wr(REG_CMD, {30'h0, c});
    n = 0;
    q = 32'h1;
    while (q[ST_BUSY] !== 1'b0 && n < 400) begin
      ahb(1'b0, REG_STATUS, 32'h0, 32'h0, q);
      n++;
    end
    // A command that never goes idle ends the run as a failure
    if (n >= 400) begin
      fails++;
      print_verdict;
    end
  endtask : cmd
  always @(posedge hclk) begin
    if (rd_dp && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 0) cmp(note[31:0], note[63:32], hrdata);
    end
    rd_dp <= hsel && htrans[1] && !hwrite;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    logic [17:0] s;
    void'($urandom(32'h9e39));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(REG_STATUS, 32'h0, 32'h7);
    rd(8'h20, 32'h0, 32'hffffffff);
    $display("test reset done");
    s = 18'($urandom);
    cmd(CMD_READ, s, 8'h0);
    rd(REG_RDATA, 32'hff, 32'hff);
    $display("test erased read done");
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($urandom);
      cmd(CMD_LOAD, {s[17:8], 8'h05 - 8'(2 * i)}, d[i]);
      rd(REG_STATUS, 32'h2, 32'h2);
    end
    repeat (GAP + 10) @(posedge hclk);
    rd(REG_STATUS, 32'h0, 32'h2);
    cmd(CMD_READ, {s[17:8], 8'h01}, 8'h0);
    rd(REG_RDATA, {24'h0, ~d[2][7], 7'h0}, 32'h80);
    cmd(CMD_POLL, {s[17:8], 8'h01}, 8'h0);
    rd(REG_STATUS, 32'h4, 32'h4);
    rd(REG_RDATA, {24'h0, d[2]}, 32'hff);
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_READ, {s[17:8], 8'h05 - 8'(2 * i)}, 8'h0);
      rd(REG_RDATA, {24'h0, d[i]}, 32'hff);
    end
    wr(REG_STATUS, 32'h4);
    rd(REG_STATUS, 32'h0, 32'h4);
    $display("test sector load done");
    print_verdict;
  end
endmodule : sector_flash_program_control_bench
`default_nettype wire
